// ==== hw/esr_params.svh ====
// Purpose: constants of the embedded synchronous RAM block
// Assumes: included by the package and the top module
// Notes:   offsets are AXI4-Lite byte addresses of aligned words
`ifndef ESR_PARAMS_SVH
`define ESR_PARAMS_SVH

// storage geometry (one 18-bit word = two bytes, each with parity)
`define ESR_DW            18
`define ESR_AW            8
`define ESR_DEPTH         256
`define ESR_PAW           12
`define ESR_SMALL_MASK    8'h1F
`define ESR_HALF_MASK     8'h7F

// register byte offsets
`define ESR_OFF_CTRL      8'h00
`define ESR_OFF_SHIFT     8'h04
`define ESR_OFF_INIT_ADDR 8'h08
`define ESR_OFF_INIT_DATA 8'h0C
`define ESR_OFF_STATUS    8'h10

// control field positions
`define ESR_CTRL_MODE_LO  0
`define ESR_CTRL_MODE_HI  2
`define ESR_CTRL_SIZE_LO  3
`define ESR_CTRL_SIZE_HI  4
`define ESR_CTRL_OUT_EN   5
`define ESR_CTRL_FLOW     6
`define ESR_CTRL_LOCK     7
`define ESR_CTRL_WID_LO   8
`define ESR_CTRL_WID_HI   9

// status bit positions
`define ESR_ST_CFG_ERR    0
`define ESR_ST_LOCKED     1
`define ESR_ST_COLLIDE    2
`define ESR_ST_INIT_REF   3

// reset values
`define ESR_CTRL_RST      10'h008
`define ESR_SHIFT_RST     8'h10

// AXI responses
`define ESR_RESP_OKAY     2'h0
`define ESR_RESP_SLVERR   2'h2

`endif

// ==== hw/esr_pkg.sv ====
// Purpose: types shared by the embedded synchronous RAM block
// Assumes: esr_params.svh gives the widths
// Notes:   mode and size codes follow declaration order
`include "esr_params.svh"

package esr_pkg;

	// storage modes
	typedef enum logic [2:0] {
		ESR_MODE_TDP,
		ESR_MODE_SDP,
		ESR_MODE_SP,
		ESR_MODE_ROM,
		ESR_MODE_FIFO,
		ESR_MODE_SHIFT,
		ESR_MODE_SPLIT
	} esr_mode_t;

	// block sizes
	typedef enum logic [1:0] {
		ESR_SIZE_SMALL,
		ESR_SIZE_MEDIUM,
		ESR_SIZE_LARGE
	} esr_size_t;

	// one fabric-side port request
	typedef struct packed {
		logic                 we;
		logic [`ESR_PAW-1:0]  addr;
		logic [`ESR_DW-1:0]   din;
	} esr_req_t;

endpackage : esr_pkg

// ==== hw/esr_ram.sv ====
// Purpose: embedded synchronous RAM block, configurable over AXI4-Lite
// Assumes: fabric ports and clears come from logic on clk_i
// Notes:   writes land on the falling edge from registered inputs
`timescale 1ns/1ns
`default_nettype none
`include "esr_params.svh"

// Contract
// - all storage modes, parity bits, size-limited
// - registered inputs, optional read output stage
// - true dual-port only medium and large
// - simple dual-port read-during-write returns old data; with flow-through on, the new word shows after the falling edge
// - single-port: exclusive access, write-through visible
// - medium block splits into two halves
// - port A narrow writes, port B wide
// - inputs registered, self-timed falling-edge strobe
// - output register can be bypassed
// - flow-through read on falling-edge read address
// - input clear immediate, output follows next edge
// - output clear immediate and visible
// - large block clears only output registers
// - large block no preload; lock after writing
// - blocks widen in parallel without glue
// - each byte carries one parity bit
// - shift mode writes falling, reads rising
module esr_ram (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	// AXI4-Lite write channels
	input  wire logic [7:0]           s_awaddr_i,
	input  wire logic                 s_awvalid_i,
	output logic                      s_awready_o,
	input  wire logic [31:0]          s_wdata_i,
	input  wire logic [3:0]           s_wstrb_i,
	input  wire logic                 s_wvalid_i,
	output logic                      s_wready_o,
	output logic [1:0]                s_bresp_o,
	output logic                      s_bvalid_o,
	input  wire logic                 s_bready_i,
	// AXI4-Lite read channels
	input  wire logic [7:0]           s_araddr_i,
	input  wire logic                 s_arvalid_i,
	output logic                      s_arready_o,
	output logic [31:0]               s_rdata_o,
	output logic [1:0]                s_rresp_o,
	output logic                      s_rvalid_o,
	input  wire logic                 s_rready_i,
	// fabric ports
	input  wire esr_pkg::esr_req_t    porta_i,
	input  wire esr_pkg::esr_req_t    portb_i,
	input  wire logic                 inclr_i,
	input  wire logic                 outclr_i,
	output logic [`ESR_DW-1:0]        qa_o,
	output logic [`ESR_DW-1:0]        qb_o
);
	import esr_pkg::*;

	// word index of a port A address for its write width
	function automatic logic [7:0] esr_word(input logic [11:0] a,
	                                        input logic [1:0]  w);
		case (w)
			2'h1:    return a[8:1];
			2'h2:    return a[11:4];
			default: return a[7:0];
		endcase
	endfunction : esr_word

	// physical word after size and split masking
	function automatic logic [7:0] esr_phys(input logic [7:0] wd,
	                                        input esr_size_t s,
	                                        input esr_mode_t m,
	                                        input logic      upper);
		if (m == ESR_MODE_SPLIT)
			return {upper, 7'(wd & `ESR_HALF_MASK)};
		else if (s == ESR_SIZE_SMALL)
			return wd & `ESR_SMALL_MASK;
		else
			return wd;
	endfunction : esr_phys

	// narrow write merged into the old word
	function automatic logic [17:0] esr_merge(input logic [17:0] old,
	                                          input logic [17:0] din,
	                                          input logic [1:0]  w,
	                                          input logic [11:0] a);
		logic [17:0] m;
		logic [4:0]  bi;
		m  = old;
		bi = a[3] ? (5'h09 + {2'h0, a[2:0]}) : {2'h0, a[2:0]};
		case (w)
			2'h1: begin                   // byte plus its parity bit
				if (a[0])
					m[17:9] = din[8:0];
				else
					m[8:0] = din[8:0];
			end
			2'h2:    m[bi] = din[0];      // single data bit
			default: m = din;
		endcase
		return m;
	endfunction : esr_merge

	// whether a mode exists on a given size
	function automatic logic esr_ok(input esr_mode_t m, input esr_size_t s);
		if (s != ESR_SIZE_SMALL && s != ESR_SIZE_MEDIUM && s != ESR_SIZE_LARGE)
			return 1'b0;
		else if (m == ESR_MODE_TDP && s == ESR_SIZE_SMALL)
			return 1'b0;
		else if (m == ESR_MODE_SHIFT && s == ESR_SIZE_LARGE)
			return 1'b0;
		else if (m == ESR_MODE_SPLIT && s != ESR_SIZE_MEDIUM)
			return 1'b0;
		else
			return m <= ESR_MODE_SPLIT;
	endfunction : esr_ok

	// storage array, two parity-carrying bytes per word
	logic [`ESR_DW-1:0] mem [`ESR_DEPTH];

	// control and status
	logic [9:0]  ctrl_reg;                 // mode, size, options
	logic [7:0]  shift_len_reg;            // tap length in words
	logic [7:0]  init_addr_reg;            // preload address
	logic        cfg_err_reg;              // requested mode refused
	logic        locked_reg;               // rom writes closed
	logic        collide_reg;              // sticky collision flag
	logic        init_ref_reg;             // sticky preload refusal
	logic        init_we_reg;              // preload pending
	logic [17:0] init_data_reg;            // preload word

	// AXI state
	logic        aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
	logic        awready_reg, wready_reg, arready_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [3:0]  wstrb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic        aw_full_next, w_full_next, rvalid_next, wr_fire;

	// datapath
	esr_req_t    a_reg, b_reg;             // input registers
	logic [7:0]  ft_addr_reg;              // falling-edge read address
	logic [7:0]  ptr_reg, ptr_prev;        // shift pointer
	logic [17:0] old_b_reg;                // word before a colliding write
	logic        hit_reg;                  // collision seen at this write
	logic [17:0] qa_out_reg, qb_out_reg;   // output registers
	logic [17:0] qa_raw, qb_raw, wa_merged;
	logic [7:0]  wa_word, wb_word;
	logic        we_a_eff, we_b_eff, collide_now, in_clr_n, out_clr_n;
	esr_mode_t   mode_req, mode;
	esr_size_t   size;
	logic [1:0]  wid;
	logic        flow_eff;

	// configuration decode; unsupported requests fall back to simple dp
	assign mode_req = esr_mode_t'(ctrl_reg[`ESR_CTRL_MODE_HI:`ESR_CTRL_MODE_LO]);
	assign size     = esr_size_t'(ctrl_reg[`ESR_CTRL_SIZE_HI:`ESR_CTRL_SIZE_LO]);
	assign mode     = esr_ok(mode_req, size) ? mode_req : ESR_MODE_SDP;
	assign wid      = (mode == ESR_MODE_TDP || mode == ESR_MODE_SDP ||
	                   mode == ESR_MODE_FIFO) ?
	                  ctrl_reg[`ESR_CTRL_WID_HI:`ESR_CTRL_WID_LO] : 2'h0;
	assign flow_eff = ctrl_reg[`ESR_CTRL_FLOW] && size != ESR_SIZE_LARGE &&
	                  mode == ESR_MODE_SDP;

	// clears: the large block has no input clear
	assign in_clr_n  = rst_n_i & ~(inclr_i & (size != ESR_SIZE_LARGE));
	assign out_clr_n = rst_n_i & ~outclr_i;

	// AXI handshake bookkeeping
	assign wr_fire      = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign aw_full_next = wr_fire ? 1'b0 :
	                      (aw_full_reg | (s_awvalid_i & awready_reg));
	assign w_full_next  = wr_fire ? 1'b0 :
	                      (w_full_reg | (s_wvalid_i & wready_reg));
	assign rvalid_next  = rvalid_reg ? ~s_rready_i : (s_arvalid_i & arready_reg);

	// address and data channels held until both are in
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awready_reg <= ~aw_full_next;
			wready_reg  <= ~w_full_next;
			if (s_awvalid_i && awready_reg)
				awaddr_reg <= s_awaddr_i;
			if (s_wvalid_i && wready_reg) begin
				wdata_reg <= s_wdata_i;
				wstrb_reg <= s_wstrb_i;
			end
		end
	end

	// write response
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `ESR_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			if (awaddr_reg == `ESR_OFF_CTRL || awaddr_reg == `ESR_OFF_SHIFT ||
			    awaddr_reg == `ESR_OFF_INIT_ADDR ||
			    awaddr_reg == `ESR_OFF_INIT_DATA || awaddr_reg == `ESR_OFF_STATUS)
				bresp_reg <= `ESR_RESP_OKAY;
			else
				bresp_reg <= `ESR_RESP_SLVERR;
		end else if (s_bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	// register writes; lock is set-only and sticks until reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg      <= `ESR_CTRL_RST;
			shift_len_reg <= `ESR_SHIFT_RST;
			init_addr_reg <= 8'h00;
		end else if (wr_fire) begin
			if (awaddr_reg == `ESR_OFF_CTRL) begin
				if (wstrb_reg[0])
					ctrl_reg[6:0] <= wdata_reg[6:0];
				if (wstrb_reg[1])
					ctrl_reg[9:8] <= wdata_reg[9:8];
			end else if (awaddr_reg == `ESR_OFF_SHIFT && wstrb_reg[0]) begin
				shift_len_reg <= (wdata_reg[7:0] == 8'h00) ? 8'h01 : wdata_reg[7:0];
			end else if (awaddr_reg == `ESR_OFF_INIT_ADDR && wstrb_reg[0]) begin
				init_addr_reg <= wdata_reg[7:0];
			end
		end
	end

	// rom lock, preload requests and sticky status
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			locked_reg    <= 1'b0;
			init_we_reg   <= 1'b0;
			init_data_reg <= 18'h00000;
			init_ref_reg  <= 1'b0;
			collide_reg   <= 1'b0;
			cfg_err_reg   <= 1'b0;
		end else begin
			cfg_err_reg <= ~esr_ok(mode_req, size);
			if (wr_fire && awaddr_reg == `ESR_OFF_CTRL && wstrb_reg[0] &&
			    wdata_reg[`ESR_CTRL_LOCK] && mode == ESR_MODE_ROM)
				locked_reg <= 1'b1;
			// preload only where the size keeps initial contents
			init_we_reg <= wr_fire && awaddr_reg == `ESR_OFF_INIT_DATA &&
			               size != ESR_SIZE_LARGE;
			if (wr_fire && awaddr_reg == `ESR_OFF_INIT_DATA)
				init_data_reg <= wdata_reg[17:0];
			// set wins over a write-one clear in the same cycle
			if (wr_fire && awaddr_reg == `ESR_OFF_INIT_DATA &&
			    size == ESR_SIZE_LARGE)
				init_ref_reg <= 1'b1;
			else if (wr_fire && awaddr_reg == `ESR_OFF_STATUS &&
			         wdata_reg[`ESR_ST_INIT_REF])
				init_ref_reg <= 1'b0;
			if (collide_now)
				collide_reg <= 1'b1;
			else if (wr_fire && awaddr_reg == `ESR_OFF_STATUS &&
			         wdata_reg[`ESR_ST_COLLIDE])
				collide_reg <= 1'b0;
		end
	end

	// register reads; unmapped answers slverr with zero data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `ESR_RESP_OKAY;
		end else begin
			rvalid_reg  <= rvalid_next;
			arready_reg <= ~rvalid_next;
			if (s_arvalid_i && arready_reg && !rvalid_reg) begin
				rresp_reg <= `ESR_RESP_OKAY;
				if (s_araddr_i == `ESR_OFF_CTRL)
					rdata_reg <= {22'h000000, ctrl_reg};
				else if (s_araddr_i == `ESR_OFF_SHIFT)
					rdata_reg <= {24'h000000, shift_len_reg};
				else if (s_araddr_i == `ESR_OFF_INIT_ADDR)
					rdata_reg <= {24'h000000, init_addr_reg};
				else if (s_araddr_i == `ESR_OFF_INIT_DATA)
					rdata_reg <= {14'h0000, init_data_reg};
				else if (s_araddr_i == `ESR_OFF_STATUS)
					rdata_reg <= {28'h0000000, init_ref_reg, collide_reg,
					              locked_reg, cfg_err_reg};
				else begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= `ESR_RESP_SLVERR;
				end
			end
		end
	end

	// fabric input registers, cleared at once by the input clear
	always_ff @(posedge clk_i or negedge in_clr_n) begin
		if (!in_clr_n) begin
			a_reg <= '0;
			b_reg <= '0;
		end else begin
			a_reg <= porta_i;
			b_reg <= portb_i;
		end
	end

	// word addresses and write qualification
	assign wa_word   = esr_phys(esr_word(a_reg.addr, wid), size, mode, 1'b0);
	assign wb_word   = esr_phys(b_reg.addr[7:0], size, mode, 1'b1);
	assign wa_merged = esr_merge(mem[wa_word], a_reg.din, wid, a_reg.addr);
	// rom on the large block takes port writes until locked
	assign we_a_eff  = a_reg.we && (mode != ESR_MODE_ROM ||
	                   (size == ESR_SIZE_LARGE && !locked_reg));
	// port B writes only where it owns a write path
	assign we_b_eff  = b_reg.we && (mode == ESR_MODE_TDP ||
	                   mode == ESR_MODE_SPLIT);
	assign collide_now = we_a_eff && wa_word == wb_word &&
	                     (mode == ESR_MODE_SDP || mode == ESR_MODE_FIFO ||
	                      mode == ESR_MODE_TDP);
	assign ptr_prev  = (ptr_reg == 8'h00) ? (shift_len_reg - 8'h01) :
	                   (ptr_reg - 8'h01);

	// shift pointer walks the tap window once per rising edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ptr_reg <= 8'h00;
		else if (mode != ESR_MODE_SHIFT || ptr_reg >= shift_len_reg - 8'h01)
			ptr_reg <= 8'h00;
		else
			ptr_reg <= ptr_reg + 8'h01;
	end

	// self-timed write strobe: falling edge after inputs are registered,
	// so address and data have settled half a cycle before the write
	always_ff @(negedge clk_i) begin
		if (init_we_reg)
			mem[init_addr_reg] <= init_data_reg;
		else if (mode == ESR_MODE_SHIFT)
			mem[ptr_prev] <= a_reg.din;
		else if (we_a_eff)
			mem[wa_word] <= wa_merged;
		if (we_b_eff && !init_we_reg)
			mem[wb_word] <= b_reg.din;
	end

	// old word snapshot for a read colliding with a write
	always_ff @(negedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			old_b_reg   <= 18'h00000;
			hit_reg     <= 1'b0;
			ft_addr_reg <= 8'h00;
		end else begin
			old_b_reg   <= mem[wb_word];
			hit_reg     <= collide_now;
			ft_addr_reg <= esr_phys(portb_i.addr[7:0], size, mode, 1'b1);
		end
	end

	// raw array reads; before the falling edge a colliding read shows
	// a don't-care word, after it the old word
	always_comb begin
		qa_raw = mem[wa_word];
		if (mode == ESR_MODE_SHIFT)
			qb_raw = mem[ptr_reg];
		else if (flow_eff)
			qb_raw = mem[ft_addr_reg];
		else if (hit_reg)
			qb_raw = old_b_reg;
		else
			qb_raw = mem[wb_word];
	end

	// output registers, cleared at once by the output clear
	always_ff @(posedge clk_i or negedge out_clr_n) begin
		if (!out_clr_n) begin
			qa_out_reg <= 18'h00000;
			qb_out_reg <= 18'h00000;
		end else begin
			qa_out_reg <= qa_raw;
			qb_out_reg <= qb_raw;
		end
	end

	// bypassable output stage; flow-through always bypasses
	assign qa_o = ctrl_reg[`ESR_CTRL_OUT_EN] ? qa_out_reg : qa_raw;
	assign qb_o = (ctrl_reg[`ESR_CTRL_OUT_EN] && !flow_eff) ?
	              qb_out_reg : qb_raw;

	// bus outputs
	assign s_awready_o = awready_reg;
	assign s_wready_o  = wready_reg;
	assign s_bvalid_o  = bvalid_reg;
	assign s_bresp_o   = bresp_reg;
	assign s_arready_o = arready_reg;
	assign s_rvalid_o  = rvalid_reg;
	assign s_rdata_o   = rdata_reg;
	assign s_rresp_o   = rresp_reg;

	// checks
	logic [17:0] mem_at_wa;
	assign mem_at_wa = mem[wa_word];

	sequence s_port_write;
		we_a_eff && !we_b_eff && !init_we_reg && mode != ESR_MODE_SHIFT;
	endsequence

	a_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_port_write |=> mem[$past(wa_word)] == $past(wa_merged))
		else $error("registered write did not land");
	a_rom_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(locked_reg && mode == ESR_MODE_ROM && a_reg.we && !init_we_reg &&
		 !we_b_eff) |=> mem[$past(wa_word)] == $past(mem_at_wa))
		else $error("locked rom was written");
	a_out_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		outclr_i |-> qa_out_reg == 18'h00000 && qb_out_reg == 18'h00000)
		else $error("output clear not immediate");
	a_in_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(inclr_i && size != ESR_SIZE_LARGE) |-> a_reg == '0 && b_reg == '0)
		else $error("input clear not immediate");
	a_large_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(size == ESR_SIZE_LARGE && $past(size) == ESR_SIZE_LARGE &&
		 $past(rst_n_i)) |-> a_reg == $past(porta_i))
		else $error("large block input registers cleared");
	a_small_no_tdp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		size == ESR_SIZE_SMALL |-> mode != ESR_MODE_TDP && !we_b_eff)
		else $error("true dual-port on small block");
	a_split_halves: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode == ESR_MODE_SPLIT |-> !wa_word[7] && wb_word[7])
		else $error("split halves overlap");
	a_single_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode == ESR_MODE_SP |-> !we_b_eff)
		else $error("second write path in single-port");
	a_collide_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		collide_now |=> collide_reg ##0 qb_raw == old_b_reg)
		else $error("collision not flagged or not old data");
	a_shift_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode == ESR_MODE_SHIFT && $past(mode) == ESR_MODE_SHIFT &&
		 $past(ptr_reg) < shift_len_reg - 8'h01 &&
		 $stable(shift_len_reg)) |-> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("shift pointer did not advance");
	a_bypass_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!ctrl_reg[`ESR_CTRL_OUT_EN]) |-> qa_o == qa_raw)
		else $error("bypass still registered");

endmodule : esr_ram
`default_nettype wire

// ==== tb/esr_fabric.sv ====
// Purpose: fabric-side user logic that drives the RAM ports
// Assumes: runs on the bench clock, drives by non-blocking assignment
// Notes:   write enables last one cycle; stale data lines are inverted
`timescale 1ns/1ns
`default_nettype none
module esr_fabric (
	// clock
	input  wire logic             clk_i,
	// ram ports
	output var esr_pkg::esr_req_t porta_o,
	output var esr_pkg::esr_req_t portb_o,
	output var logic              inclr_o,
	output var logic              outclr_o
);
	import esr_pkg::*;
	// idle fabric at time zero
	initial begin
		porta_o  = '0;
		portb_o  = '0;
		inclr_o  = 1'b0;
		outclr_o = 1'b0;
	end
	// one write on port a or b, then the enable drops for good
	task automatic put(input logic pb, input logic [11:0] a,
			input logic [17:0] d);
		@(posedge clk_i);
		if (pb)
			portb_o <= '{1'b1, a, d};
		else
			porta_o <= '{1'b1, a, d};
		@(posedge clk_i);
		// data no longer qualified, so it must not look valid
		if (pb)
			portb_o <= '{1'b0, a, ~d};
		else
			porta_o <= '{1'b0, a, ~d};
	endtask : put
	// present a read address on port b
	task automatic look(input logic [11:0] a);
		@(posedge clk_i);
		portb_o <= '{1'b0, a, 18'h0_0000};
	endtask : look
	// set both asynchronous clears
	task automatic clr(input logic i, input logic o);
		@(posedge clk_i);
		inclr_o  <= i;
		outclr_o <= o;
	endtask : clr
endmodule : esr_fabric
`default_nettype wire

// ==== tb/test_esr_ram.sv ====
// Purpose: self-checking bench for the embedded synchronous RAM block
// Assumes: esr_fabric drives the fabric ports
// Notes:   bus answers are sampled at the falling edge before use
`timescale 1ns/1ns
`default_nettype none
`include "esr_params.svh"
module test_esr_ram;
	import esr_pkg::*;
	// one register case: address, write data, read-back, response
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0]  r;
	} esr_row_t;
	// bus side, named as the ports
	logic        clk_i = 1'b0, rst_n_i = 1'b0;
	logic [7:0]  s_awaddr_i = 8'h00, s_araddr_i = 8'h00;
	logic        s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
	logic        s_arvalid_i = 1'b0, s_rready_i = 1'b0;
	logic [31:0] s_wdata_i = 32'h0000_0000;
	logic [3:0]  s_wstrb_i = 4'hF;
	logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
	logic [1:0]  s_bresp_o, s_rresp_o;
	logic [31:0] s_rdata_o;
	// fabric side
	esr_req_t    porta_i, portb_i;
	logic        inclr_i, outclr_i;
	logic [17:0] qa_o, qb_o;
	int          n_errors = 0, checked = 0, cyc = 0;
	logic [33:0] got;
	// bit 7 is not stored, zero length becomes one, hole gives an error
	esr_row_t    rows [4] = '{
		'{`ESR_OFF_CTRL, 32'h0000_0081, 32'h0000_0001, `ESR_RESP_OKAY},
		'{`ESR_OFF_SHIFT, 32'h0000_0000, 32'h0000_0001, `ESR_RESP_OKAY},
		'{`ESR_OFF_INIT_ADDR, 32'h0000_0005, 32'h0000_0005, `ESR_RESP_OKAY},
		'{8'h14, 32'h0000_00FF, 32'h0000_0000, `ESR_RESP_SLVERR}};
	esr_ram dut (.clk_i, .rst_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
		.s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o,
		.s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
		.s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .porta_i,
		.portb_i, .inclr_i, .outclr_i, .qa_o, .qb_o);
	esr_fabric fab (.clk_i, .porta_o(porta_i), .portb_o(portb_i),
		.inclr_o(inclr_i), .outclr_o(outclr_i));
	// 250 MHz clock
	always #2 clk_i = ~clk_i;
	// hang guard, far above the roughly 120 cycles the tests need
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// bus answer: response above data
	task automatic chk_bus(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t bus got %h exp %h", $time, g, e);
		end
	endtask : chk_bus
	// read word on a fabric port
	task automatic chk_q(input logic [17:0] g, input logic [17:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t word got %h exp %h", $time, g, e);
		end
	endtask : chk_q
	// write: both channels offered at once, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		logic ta, tw, tb;
		int   n;
		n = 0;
		tb = 1'b0;
		// a hang leaves a response code that is never expected
		got = {2'h3, 32'hFFFF_FFFF};
		@(posedge clk_i);
		s_awaddr_i  <= a;
		s_wdata_i   <= d;
		s_awvalid_i <= 1'b1;
		s_wvalid_i  <= 1'b1;
		s_bready_i  <= 1'b1;
		while (!tb && n < 50) begin
			@(negedge clk_i);
			ta = s_awvalid_i & s_awready_o;
			tw = s_wvalid_i & s_wready_o;
			tb = s_bvalid_o === 1'b1;
			if (tb)
				got = {s_bresp_o, 32'h0000_0000};
			@(posedge clk_i);
			if (ta) s_awvalid_i <= 1'b0;
			if (tw) s_wvalid_i <= 1'b0;
			n++;
		end
		s_bready_i <= 1'b0;
		chk_bus(got, {r, 32'h0000_0000});
	endtask : wr
	// read: address held until taken, rready until rvalid seen
	task automatic rd(input logic [7:0] a, input logic [31:0] q,
			input logic [1:0] r);
		logic ta, tr;
		int   n;
		n = 0;
		tr = 1'b0;
		got = {2'h3, 32'hFFFF_FFFF};
		@(posedge clk_i);
		s_araddr_i  <= a;
		s_arvalid_i <= 1'b1;
		s_rready_i  <= 1'b1;
		while (!tr && n < 50) begin
			@(negedge clk_i);
			ta = s_arvalid_i & s_arready_o;
			tr = s_rvalid_o === 1'b1;
			if (tr)
				got = {s_rresp_o, s_rdata_o};
			@(posedge clk_i);
			if (ta) s_arvalid_i <= 1'b0;
			n++;
		end
		s_rready_i <= 1'b0;
		chk_bus(got, {r, q});
	endtask : rd
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(`ESR_OFF_CTRL, 32'h0000_0008, `ESR_RESP_OKAY);
		rd(`ESR_OFF_SHIFT, 32'h0000_0010, `ESR_RESP_OKAY);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].q, rows[i].r);
		end
		$display("test registers done");
		// small block has no true dual-port mode
		wr(`ESR_OFF_CTRL, 32'h0000_0000, `ESR_RESP_OKAY);
		rd(`ESR_OFF_STATUS, 32'h0000_0001, `ESR_RESP_OKAY);
		$display("test mode support done");
		// simple dual-port, registered output, parity bits kept
		wr(`ESR_OFF_CTRL, 32'h0000_0029, `ESR_RESP_OKAY);
		fab.put(1'b0, 12'h010, 18'h2_01AA);
		fab.look(12'h010);
		repeat (2) @(posedge clk_i);
		#1 chk_q(qb_o, 18'h2_01AA);
		fab.clr(1'b0, 1'b1);
		#1 chk_q(qb_o, 18'h0_0000);
		fab.clr(1'b0, 1'b0);
		wr(`ESR_OFF_CTRL, 32'h0000_0009, `ESR_RESP_OKAY);
		#1 chk_q(qb_o, 18'h2_01AA);
		$display("test dual-port and clear done");
		// single port, unregistered: written word shows at once
		wr(`ESR_OFF_CTRL, 32'h0000_000A, `ESR_RESP_OKAY);
		fab.put(1'b0, 12'h020, 18'h1_2345);
		@(negedge clk_i);
		#1 chk_q(qa_o, 18'h1_2345);
		$display("test write-through done");
		// true dual-port, port a one bit wide, port b full word
		wr(`ESR_OFF_CTRL, 32'h0000_0208, `ESR_RESP_OKAY);
		fab.put(1'b1, 12'h030, 18'h0_0000);
		fab.put(1'b0, 12'h309, 18'h0_0001);
		fab.look(12'h030);
		@(posedge clk_i);
		#1 chk_q(qb_o, 18'h0_0400);
		$display("test mixed width done");
		// preload word 0, then input clear shows only after the next edge
		wr(`ESR_OFF_INIT_ADDR, 32'h0000_0000, `ESR_RESP_OKAY);
		wr(`ESR_OFF_INIT_DATA, 32'h0000_3C3C, `ESR_RESP_OKAY);
		wr(`ESR_OFF_CTRL, 32'h0000_0028, `ESR_RESP_OKAY);
		fab.clr(1'b1, 1'b0);
		#1 chk_q(qb_o, 18'h0_0400);
		fab.clr(1'b0, 1'b0);
		#1 chk_q(qb_o, 18'h0_3C3C);
		// flow-through: new read address shows after the falling edge
		wr(`ESR_OFF_CTRL, 32'h0000_0049, `ESR_RESP_OKAY);
		fab.look(12'h010);
		@(negedge clk_i);
		#1 chk_q(qb_o, 18'h2_01AA);
		$display("test preload clear and flow done");
		// large block: preload refused, rom written once then locked
		wr(`ESR_OFF_CTRL, 32'h0000_0013, `ESR_RESP_OKAY);
		wr(`ESR_OFF_INIT_DATA, 32'h0000_0001, `ESR_RESP_OKAY);
		rd(`ESR_OFF_STATUS, 32'h0000_000C, `ESR_RESP_OKAY);
		fab.put(1'b0, 12'h040, 18'h3_0F0F);
		wr(`ESR_OFF_CTRL, 32'h0000_0093, `ESR_RESP_OKAY);
		fab.put(1'b0, 12'h040, 18'h0_1234);
		// input clear must not move the large block's address
		fab.clr(1'b1, 1'b0);
		#1 chk_q(qa_o, 18'h3_0F0F);
		fab.clr(1'b0, 1'b0);
		rd(`ESR_OFF_STATUS, 32'h0000_000E, `ESR_RESP_OKAY);
		$display("test large block done");
		final_report();
	end
endmodule : test_esr_ram
`default_nettype wire
